/* File: vrp_top.sv */
// velocity ramp profile generator with parameter access port
`timescale 1ns/1ns
`include "vrp_cfg.svh"

module vrp_top
  import vrp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `VRP_TICK_NS / `VRP_CLK_NS
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  input wire logic [15:0] I_PAR_ADDR,
  input wire logic I_PAR_WR,
  input wire logic I_PAR_RD,
  input wire logic [31:0] I_PAR_WDATA,
  input wire logic I_POWER_EN,
  input wire logic I_OP_END,
  input wire logic [3:0] I_OP_MODE,
  input wire logic I_MOVE_START,
  input wire logic signed [31:0] I_TARGET_VEL,
  output logic [31:0] O_PAR_RDATA,
  output logic O_PAR_ACK,
  output logic O_PAR_ERR,
  output logic signed [31:0] O_REF_VEL,
  output logic O_PROFILE_ACTIVE,
  output logic O_JERK_ACTIVE,
  output logic O_MOVING
);

  // profile use class of a mode
  function automatic vrp_class_type vrp_class(input logic [3:0] m);
    case (vrp_mode_type'(m))
      MD_JOG, MD_PROF_POS, MD_HOMING, MD_SEQ_ABS, MD_SEQ_ADD, MD_SEQ_REL,
      MD_SEQ_REF: vrp_class = CL_ALWAYS;
      MD_PROF_VEL, MD_SEQ_VEL: vrp_class = CL_OPTION;
      default: vrp_class = CL_NONE;
    endcase
  endfunction : vrp_class

  // jerk code to window shift; none for an illegal code
  function automatic logic [3:0] vrp_jerk_shift(input logic [15:0] c);
    case (c)
      16'h0001: vrp_jerk_shift = 4'h0;
      16'h0002: vrp_jerk_shift = 4'h1;
      16'h0004: vrp_jerk_shift = 4'h2;
      16'h0008: vrp_jerk_shift = 4'h3;
      16'h0010: vrp_jerk_shift = 4'h4;
      16'h0020: vrp_jerk_shift = 4'h5;
      16'h0040: vrp_jerk_shift = 4'h6;
      16'h0080: vrp_jerk_shift = 4'h7;
      default: vrp_jerk_shift = 4'h8;
    endcase
  endfunction : vrp_jerk_shift

  logic [31:0] max_vel_r;
  logic [31:0] acc_r;
  logic [31:0] dec_r;
  logic [15:0] jerk_r;
  logic [15:0] ena_r;
  logic [31:0] act_max_r;
  logic [31:0] act_acc_r;
  logic [31:0] act_dec_r;
  logic [15:0] act_jerk_r;
  logic signed [31:0] ref_r;
  logic [15:0] tick_cnt_r;
  logic tick_r;
  vrp_state_type state_r;
  vrp_state_type state_nxt;
  vrp_class_type cls;
  logic apply;
  logic jerk_on;
  logic [31:0] dec_min;
  logic hit;
  logic refuse;
  logic wr_max;
  logic wr_acc;
  logic wr_dec;
  logic wr_jerk;
  logic wr_ena;
  logic [31:0] rd_val;
  logic signed [33:0] v;
  logic signed [33:0] t;
  logic signed [33:0] t0;
  logic signed [33:0] mx;
  logic signed [33:0] a;
  logic signed [33:0] d;
  logic signed [33:0] nv;
  logic signed [33:0] lim;
  logic accel;
  logic signed [31:0] ref_nxt;
  logic signed [31:0] goal;
  logic [3:0] jerk_sh;

  vrp_smooth_if sif();

  // mode class, profile use and least deceleration
  always_comb begin
    cls = vrp_class(I_OP_MODE);
    apply = (cls == CL_ALWAYS) ||
            ((cls == CL_OPTION) && (ena_r == `VRP_ENA_ON));
    jerk_on = (cls == CL_ALWAYS) && (act_jerk_r != `VRP_JERK_OFF);
    dec_min = (cls == CL_OPTION) ? `VRP_DEC_MIN_VEL :
              `VRP_DEC_MIN_POS;
  end

  // parameter write checks; zero slope writes are taken but change nothing
  always_comb begin
    hit = 1'b1;
    refuse = 1'b0;
    wr_max = 1'b0;
    wr_acc = 1'b0;
    wr_dec = 1'b0;
    wr_jerk = 1'b0;
    wr_ena = 1'b0;
    case (I_PAR_ADDR)
      `VRP_ADDR_MAX_VEL: begin
        refuse = I_POWER_EN || (I_PAR_WDATA < `VRP_VAL_MIN) ||
                 (I_PAR_WDATA > `VRP_VAL_MAX);
        wr_max = !refuse;
      end
      `VRP_ADDR_ACC: begin
        refuse = I_PAR_WDATA > `VRP_VAL_MAX;
        wr_acc = !refuse && (I_PAR_WDATA != 32'h0000_0000);
      end
      `VRP_ADDR_DEC: begin
        refuse = (I_PAR_WDATA > `VRP_VAL_MAX) ||
                 ((I_PAR_WDATA != 32'h0000_0000) &&
                  (I_PAR_WDATA < dec_min));
        wr_dec = !refuse && (I_PAR_WDATA != 32'h0000_0000);
      end
      `VRP_ADDR_JERK: begin
        refuse = !I_OP_END || (I_PAR_WDATA[31:16] != 16'h0000) ||
                 ((I_PAR_WDATA[15:0] != `VRP_JERK_OFF) &&
                  (vrp_jerk_shift(I_PAR_WDATA[15:0]) == 4'h8));
        wr_jerk = !refuse;
      end
      `VRP_ADDR_ENA: begin
        refuse = I_POWER_EN || (I_PAR_WDATA > 32'(`VRP_ENA_ON));
        wr_ena = !refuse;
      end
      default: hit = 1'b0;
    endcase
  end

  // read mux, narrow settings in the low bits
  always_comb begin
    case (I_PAR_ADDR)
      `VRP_ADDR_MAX_VEL: rd_val = max_vel_r;
      `VRP_ADDR_ACC: rd_val = acc_r;
      `VRP_ADDR_DEC: rd_val = dec_r;
      `VRP_ADDR_JERK: rd_val = {16'h0000, jerk_r};
      `VRP_ADDR_ENA: rd_val = {16'h0000, ena_r};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // access answer one cycle after the strobe
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PAR_ACK <= 1'b0;
      O_PAR_ERR <= 1'b0;
      O_PAR_RDATA <= 32'h0000_0000;
    end else begin
      O_PAR_ACK <= (I_PAR_WR && hit && !refuse) || (I_PAR_RD && hit);
      O_PAR_ERR <= (I_PAR_WR && (!hit || refuse)) || (I_PAR_RD && !hit);
      if (I_PAR_RD && hit) begin
        O_PAR_RDATA <= rd_val;
      end
    end
  end

  // stored settings
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      max_vel_r <= `VRP_RST_MAX_VEL;
      acc_r <= `VRP_RST_ACC;
      dec_r <= `VRP_RST_DEC;
      jerk_r <= `VRP_RST_JERK;
      ena_r <= `VRP_RST_ENA;
    end else if (I_PAR_WR) begin
      if (wr_max) max_vel_r <= I_PAR_WDATA;
      if (wr_acc) acc_r <= I_PAR_WDATA;
      if (wr_dec) dec_r <= I_PAR_WDATA;
      if (wr_jerk) jerk_r <= I_PAR_WDATA[15:0];
      if (wr_ena) ena_r <= I_PAR_WDATA[15:0];
    end
  end

  // settings in force, taken over at the start of each movement
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      act_max_r <= `VRP_RST_MAX_VEL;
      act_acc_r <= `VRP_RST_ACC;
      act_dec_r <= `VRP_RST_DEC;
      act_jerk_r <= `VRP_RST_JERK;
    end else if (I_MOVE_START) begin
      act_max_r <= max_vel_r;
      act_acc_r <= acc_r;
      act_dec_r <= dec_r;
      act_jerk_r <= jerk_r;
    end
  end

  // one pulse per profile time unit
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // linear ramp step toward the capped target, mirrored for both signs
  always_comb begin
    v = 34'(ref_r);
    t0 = 34'(I_TARGET_VEL);
    mx = {2'b00, act_max_r};
    a = {2'b00, act_acc_r};
    d = {2'b00, act_dec_r};
    t = t0;
    if (t0 > mx) t = mx;
    else if (t0 < -mx) t = -mx;
    nv = v;
    lim = t;
    accel = ((t > v) && (v >= 0)) || ((t < v) && (v <= 0));
    if (t > v) begin
      if (v >= 0) begin
        nv = (v + a > t) ? t : v + a;
      end else begin
        lim = (t < 0) ? t : 34'sh0;
        nv = (v + d > lim) ? lim : v + d;
      end
    end else if (t < v) begin
      if (v <= 0) begin
        nv = (v - a < t) ? t : v - a;
      end else begin
        lim = (t > 0) ? t : 34'sh0;
        nv = (v - d < lim) ? lim : v - d;
      end
    end
    ref_nxt = apply ? 32'(nv) : I_TARGET_VEL;
    goal = apply ? 32'(t) : I_TARGET_VEL; // where the ramp settles
  end

  // movement state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (I_MOVE_START) state_nxt = ST_RAMP;
      ST_RAMP: if (tick_r && (ref_nxt == goal)) state_nxt = ST_HOLD;
      ST_HOLD: begin
        if (I_MOVE_START) state_nxt = ST_RAMP;
        else if (I_OP_END) state_nxt = ST_IDLE;
        else if (ref_r != goal) state_nxt = ST_RAMP;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  // ramp output, stepped once per tick while a movement runs
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ref_r <= 32'sh0000_0000;
    end else if (tick_r && (state_r != ST_IDLE)) begin
      ref_r <= ref_nxt;
    end
  end

  // jerk smoother fed with the ramp output
  always_comb begin
    sif.tick = tick_r && (state_r != ST_IDLE);
    sif.load = I_MOVE_START;
    jerk_sh = vrp_jerk_shift(I_MOVE_START ? jerk_r : act_jerk_r);
    sif.shift = jerk_sh[2:0];
    sif.din = ref_r;
  end

  vrp_smoother u_smoother (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RESET_N),
    .sif(sif)
  );

  // registered outputs
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_REF_VEL <= 32'sh0000_0000;
      O_PROFILE_ACTIVE <= 1'b0;
      O_JERK_ACTIVE <= 1'b0;
      O_MOVING <= 1'b0;
    end else begin
      O_REF_VEL <= jerk_on ? sif.dout : ref_r;
      O_PROFILE_ACTIVE <= apply;
      O_JERK_ACTIVE <= jerk_on;
      O_MOVING <= state_r != ST_IDLE;
    end
  end

  // write refusals, cap and ramp step guards
  a_zero_acc_kept: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    (I_PAR_WR && I_PAR_ADDR == `VRP_ADDR_ACC && I_PAR_WDATA == 32'h0) |=>
    $stable(acc_r) && O_PAR_ACK)
    else $error("zero write changed slope");
  a_enable_locked: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    (I_PAR_WR && I_PAR_ADDR == `VRP_ADDR_ENA && I_POWER_EN) |=>
    O_PAR_ERR && $stable(ena_r))
    else $error("enable changed while powered");
  a_cap_holds: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    apply |-> (t <= mx) && (t >= -mx))
    else $error("target above cap");
  a_no_profile: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    (tick_r && state_r != ST_IDLE && cls == CL_NONE) |=>
    ref_r == $past(I_TARGET_VEL))
    else $error("profile used in torque mode");
  a_accel_step: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    (tick_r && state_r != ST_IDLE && apply && accel) |=>
    (34'(ref_r) - $past(v) <= $past(a)) &&
    ($past(v) - 34'(ref_r) <= $past(a)))
    else $error("ramp step above slope");
  a_dec_floor: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    (I_PAR_WR && I_PAR_ADDR == `VRP_ADDR_DEC && cls != CL_OPTION &&
     I_PAR_WDATA != 32'h0 && I_PAR_WDATA < `VRP_DEC_MIN_POS) |=>
    O_PAR_ERR && $stable(dec_r))
    else $error("low deceleration taken");
  a_jerk_locked: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    (I_PAR_WR && I_PAR_ADDR == `VRP_ADDR_JERK && !I_OP_END) |=>
    O_PAR_ERR && $stable(jerk_r))
    else $error("jerk changed while active");
  a_range_reject: assert property (
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    (I_PAR_WR && I_PAR_ADDR == `VRP_ADDR_MAX_VEL &&
     I_PAR_WDATA > `VRP_VAL_MAX) |=>
    O_PAR_ERR && $stable(max_vel_r))
    else $error("cap out of range taken");

endmodule : vrp_top

/* File: vrp_cfg.svh */
// constants for the velocity ramp profile generator
`ifndef VRP_CFG_SVH
`define VRP_CFG_SVH

// parameter addresses
`define VRP_ADDR_MAX_VEL 16'h0612
`define VRP_ADDR_ACC 16'h0614
`define VRP_ADDR_DEC 16'h0616
`define VRP_ADDR_JERK 16'h061A
`define VRP_ADDR_ENA 16'h0656

// factory values
`define VRP_RST_MAX_VEL 32'h0000_3390
`define VRP_RST_ACC 32'h0000_0258
`define VRP_RST_DEC 32'h0000_0258
`define VRP_RST_JERK 16'h0000
`define VRP_RST_ENA 16'h0001

// value ranges and encodings
`define VRP_VAL_MIN 32'h0000_0001
`define VRP_VAL_MAX 32'h7FFF_FFFF
`define VRP_DEC_MIN_VEL 32'h0000_0001
`define VRP_DEC_MIN_POS 32'h0000_0078
`define VRP_ENA_OFF 16'h0000
`define VRP_ENA_ON 16'h0001
`define VRP_JERK_OFF 16'h0000

// profile time unit and clock period, both in ns
`define VRP_TICK_NS 1000000
`define VRP_CLK_NS 20

`endif

/* File: vrp_pkg.sv */
// types for the velocity ramp profile generator
package vrp_pkg;

  // operating mode, sequence moves carry their move type
  typedef enum logic [3:0] {
    MD_JOG = 4'h0,
    MD_PROF_POS = 4'h1,
    MD_HOMING = 4'h2,
    MD_SEQ_ABS = 4'h3,
    MD_SEQ_ADD = 4'h4,
    MD_SEQ_REL = 4'h5,
    MD_SEQ_REF = 4'h6,
    MD_PROF_VEL = 4'h7,
    MD_SEQ_VEL = 4'h8,
    MD_PROF_TORQUE = 4'h9,
    MD_INTERP_POS = 4'hA
  } vrp_mode_type;

  // how a mode uses the profile
  typedef enum logic [1:0] {
    CL_ALWAYS = 2'h0,
    CL_OPTION = 2'h1,
    CL_NONE = 2'h2
  } vrp_class_type;

  // movement state, gray coded along idle, ramp, hold
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAMP = 2'b01,
    ST_HOLD = 2'b11
  } vrp_state_type;

endpackage : vrp_pkg

/* File: vrp_smooth_if.sv */
// carrier between the ramp generator and the jerk smoother
`timescale 1ns/1ns
interface vrp_smooth_if;
  logic tick;
  logic load;
  logic [2:0] shift;
  logic signed [31:0] din;
  logic signed [31:0] dout;
  modport src(output tick, output load, output shift, output din,
              input dout);
  modport flt(input tick, input load, input shift, input din,
              output dout);
endinterface : vrp_smooth_if

/* File: vrp_smoother.sv */
// moving-average jerk smoother over 2**shift ticks
`timescale 1ns/1ns
module vrp_smoother
  import vrp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  vrp_smooth_if.flt sif
);

  logic signed [31:0] mem [0:127];
  logic [6:0] wp_r;
  logic signed [39:0] sum_r;
  logic signed [39:0] sum_nxt;
  logic signed [31:0] base_r;
  logic signed [31:0] dout_r;
  logic [7:0] stale_r;
  logic [7:0] win;
  logic signed [31:0] old;

  // window length and the sample leaving the window
  always_comb begin
    win = 8'h01 << sif.shift;
    old = (stale_r != 8'h00) ? base_r : mem[7'(wp_r - win[6:0])];
    sum_nxt = sum_r + 40'(sif.din) - 40'(old);
  end

  // history ring, no reset needed
  always_ff @(posedge i_clk) begin
    if (sif.tick) begin
      mem[wp_r] <= sif.din;
    end
  end

  // running sum; load restarts the window around the present value
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_r <= 7'h00;
      sum_r <= 40'sh00_0000_0000;
      base_r <= 32'sh0000_0000;
      stale_r <= 8'h00;
      dout_r <= 32'sh0000_0000;
    end else if (sif.load) begin
      sum_r <= 40'(sif.din) <<< sif.shift;
      base_r <= sif.din;
      stale_r <= win;
      dout_r <= sif.din;
    end else if (sif.tick) begin
      wp_r <= wp_r + 7'h01;
      sum_r <= sum_nxt;
      dout_r <= 32'(sum_nxt >>> sif.shift);
      if (stale_r != 8'h00) begin
        stale_r <= stale_r - 8'h01;
      end
    end
  end

  assign sif.dout = dout_r;

  // a load restarts the window and primes the output
  a_stale_reload: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    sif.load |=> stale_r == $past(win))
    else $error("window not restarted");
  a_steady_output: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    sif.load |=> dout_r == $past(sif.din))
    else $error("smoother output not primed");

endmodule : vrp_smoother

/* File: vrp_master.sv */
// parameter bus master model standing in for the fieldbus side
`timescale 1ns/1ns
module vrp_master (
  input wire logic i_clk,
  input wire logic i_ack,
  input wire logic i_err,
  input wire logic [31:0] i_rdata,
  output logic [15:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [31:0] o_wdata
);
  // idle bus at time zero
  initial begin
    o_addr = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 32'h0000_0000;
  end

  // one access: strobe for one cycle, answer one cycle after the strobe
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [31:0] d, output logic ack,
                        output logic err, output logic [31:0] rd);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = w; // caller sets power and mode state first
    o_rd = ~w;
    // the answer stands for the cycle after the taking edge only
    @(negedge i_clk);
    ack = i_ack;
    err = i_err;
    rd = i_rdata;
    o_wr = 1'b0;
    o_rd = 1'b0;
    // released lines show the inverse so stale values are not reused
    o_addr = ~a;
    o_wdata = ~d;
  endtask : access
endmodule : vrp_master

/* File: velocity_ramp_profile_tb.sv */
// self-checking bench for the velocity ramp profile generator
`timescale 1ns/1ns
`include "vrp_cfg.svh"
module velocity_ramp_profile_tb;
  localparam int unsigned TICK = 10;
  logic clk, rst_n, wr, rd, power_en, op_end, move_start, ack, err;
  logic [15:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] op_mode;
  logic signed [31:0] target_vel, ref_vel;
  logic prof_act, jerk_act, moving;
  int failures, total_checks, cycles;

  // design under test with a short tick
  vrp_top #(.TICK_CYCLES(TICK)) i_dut (
    .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_PAR_ADDR(addr),
    .I_PAR_WR(wr), .I_PAR_RD(rd), .I_PAR_WDATA(wdata),
    .I_POWER_EN(power_en), .I_OP_END(op_end), .I_OP_MODE(op_mode),
    .I_MOVE_START(move_start), .I_TARGET_VEL(target_vel),
    .O_PAR_RDATA(rdata), .O_PAR_ACK(ack), .O_PAR_ERR(err),
    .O_REF_VEL(ref_vel), .O_PROFILE_ACTIVE(prof_act),
    .O_JERK_ACTIVE(jerk_act), .O_MOVING(moving));

  // bus master partner
  vrp_master i_mst (
    .i_clk(clk), .i_ack(ack), .i_err(err), .i_rdata(rdata),
    .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // access expecting refusal or acceptance
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic e);
    logic k, r;
    logic [31:0] q;
    i_mst.access(w, a, d, k, r, q);
    chk({30'h0, k, r}, {30'h0, ~e, e});
  endtask : bus

  // good read with expected value
  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    logic k, r;
    logic [31:0] q;
    i_mst.access(1'b0, a, 32'h0, k, r, q);
    chk({30'h0, k, r}, 32'h2);
    chk(q, exp);
  endtask : rdc

  // start a movement in a mode towards a target
  task automatic move(input logic [3:0] m, input logic [31:0] t);
    @(negedge clk);
    op_mode = m;
    target_vel = t;
    move_start = 1'b1;
    @(negedge clk);
    move_start = 1'b0;
  endtask : move

  // wait for the next reference step and compare it
  task automatic next_ref(input logic [31:0] e);
    logic [31:0] old;
    int n;
    old = ref_vel;
    n = 0;
    while (ref_vel === old && n < 4 * TICK) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(ref_vel, e);
  endtask : next_ref

  // factory values and an unmapped address
  task automatic t_factory();
    rdc(`VRP_ADDR_MAX_VEL, `VRP_RST_MAX_VEL);
    rdc(`VRP_ADDR_ACC, `VRP_RST_ACC);
    rdc(`VRP_ADDR_DEC, `VRP_RST_DEC);
    rdc(`VRP_ADDR_JERK, {16'h0000, `VRP_RST_JERK});
    rdc(`VRP_ADDR_ENA, {16'h0000, `VRP_ENA_ON});
    bus(1'b0, 16'h0618, 32'h0, 1'b1);
    $display("test factory done");
  endtask : t_factory

  // range and power-lock refusals, zero slope writes taken
  task automatic t_limits();
    @(negedge clk);
    power_en = 1'b1;
    bus(1'b1, `VRP_ADDR_MAX_VEL, 32'h64, 1'b1);
    bus(1'b1, `VRP_ADDR_ENA, 32'h0, 1'b1);
    @(negedge clk);
    power_en = 1'b0;
    bus(1'b1, `VRP_ADDR_MAX_VEL, 32'h0, 1'b1);
    bus(1'b1, `VRP_ADDR_MAX_VEL, 32'h8000_0000, 1'b1);
    bus(1'b1, `VRP_ADDR_MAX_VEL, `VRP_VAL_MAX, 1'b0);
    rdc(`VRP_ADDR_MAX_VEL, `VRP_VAL_MAX);
    bus(1'b1, `VRP_ADDR_ACC, 32'h0, 1'b0);
    bus(1'b1, `VRP_ADDR_ACC, 32'h8000_0000, 1'b1);
    rdc(`VRP_ADDR_ACC, `VRP_RST_ACC);
    bus(1'b1, `VRP_ADDR_DEC, 32'h0, 1'b0);
    rdc(`VRP_ADDR_DEC, `VRP_RST_DEC);
    @(negedge clk);
    op_mode = 4'h0;
    bus(1'b1, `VRP_ADDR_DEC, `VRP_DEC_MIN_POS - 1, 1'b1);
    bus(1'b1, `VRP_ADDR_DEC, `VRP_DEC_MIN_POS, 1'b0);
    @(negedge clk);
    op_mode = 4'h7;
    bus(1'b1, `VRP_ADDR_DEC, `VRP_DEC_MIN_VEL, 1'b0);
    rdc(`VRP_ADDR_DEC, `VRP_DEC_MIN_VEL);
    bus(1'b1, `VRP_ADDR_ENA, 32'h2, 1'b1);
    $display("test limits done");
  endtask : t_limits

  // ramp up, clamp, reversal through zero, settings used next move
  task automatic t_ramp();
    logic signed [31:0] ev [15] = '{10, 20, 30, 35, 15, 0, -10, -20,
                                     -30, -35, -15, 0, 5, 10, 12};
    bus(1'b1, `VRP_ADDR_MAX_VEL, 32'd35, 1'b0);
    bus(1'b1, `VRP_ADDR_ACC, 32'd10, 1'b0);
    bus(1'b1, `VRP_ADDR_DEC, 32'd20, 1'b0);
    @(negedge clk);
    op_end = 1'b0;
    move(4'h7, 32'd100);
    for (int i = 0; i < 15; i++) begin
      if (i == 4) begin
        bus(1'b1, `VRP_ADDR_ACC, 32'd5, 1'b0);
        @(negedge clk);
        target_vel = -100;
      end
      if (i == 10) begin
        @(negedge clk);
        op_end = 1'b1;
        move(4'h7, 32'd0);
      end
      if (i == 12) move(4'h7, 32'd12);
      next_ref(ev[i]);
      if (i == 0) chk({31'h0, moving}, 32'h1);
    end
    $display("test ramp done");
  endtask : t_ramp

  // profile use by mode and enable switch
  task automatic t_modes();
    logic exp;
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, `VRP_ADDR_ENA, e, 1'b0);
      for (int m = 0; m < 11; m++) begin
        @(negedge clk);
        op_mode = m[3:0];
        repeat (3) @(posedge clk);
        #1;
        exp = (m < 7) || (m < 9 && e == 1);
        chk({31'h0, prof_act}, {31'h0, exp});
      end
      if (e == 0) begin
        move(4'h7, 32'd77);
        next_ref(32'd77);
        move(4'h9, -5);
        next_ref(-5);
      end
    end
    rdc(`VRP_ADDR_ENA, {16'h0000, `VRP_ENA_ON});
    $display("test modes done");
  endtask : t_modes

  // jerk codes, write lock and mode availability
  task automatic t_jerk();
    logic [31:0] code;
    @(negedge clk);
    op_end = 1'b0;
    bus(1'b1, `VRP_ADDR_JERK, 32'h4, 1'b1);
    @(negedge clk);
    op_end = 1'b1;
    bus(1'b1, `VRP_ADDR_JERK, 32'h3, 1'b1);
    bus(1'b1, `VRP_ADDR_JERK, 32'h1_0000, 1'b1);
    for (int i = 0; i < 9; i++) begin
      code = (i == 0) ? 32'h0 : (32'h1 << (i - 1));
      bus(1'b1, `VRP_ADDR_JERK, code, 1'b0);
      rdc(`VRP_ADDR_JERK, code);
    end
    move(4'h0, 32'd50);
    @(posedge clk);
    #1;
    chk({31'h0, jerk_act}, 32'h1);
    move(4'h7, 32'd50);
    @(posedge clk);
    #1;
    chk({31'h0, jerk_act}, 32'h0);
    $display("test jerk done");
  endtask : t_jerk

  // counts and verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  // reset then scenarios
  initial begin
    rst_n = 1'b0;
    power_en = 1'b0;
    op_end = 1'b1;
    op_mode = 4'h0;
    move_start = 1'b0;
    target_vel = 32'sd0;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_factory();
    t_limits();
    t_ramp();
    t_modes();
    t_jerk();
    complete_run();
  end
endmodule : velocity_ramp_profile_tb
